// ==== rtl/iod_decoder.sv ====
`timescale 1ns/1ps
`default_nettype none
module iod_decoder
    import iod_pkg::*;
(
    input  wire logic       clk_sys_in,
    input  wire logic       reset_in,
    input  wire logic [1:0] ext_bus_strap_in,
    input  wire iod_req_t   req_in,
    input  wire logic [2:0] divisor_latch_access_in,
    output iod_sel_t        sel_out,
    output logic [1:0]      space_out,
    output logic [31:0]     base_out,
    output logic            space_valid_out
);
    logic [1:0]  strap_sync;
    logic        captured_ff;
    logic [1:0]  space_ff;
    logic [31:0] base_ff;
    iod_sel_t    sel_ff;
    iod_sel_t    nxt_sel;
    logic        hit;
    logic [20:0] off;
    logic [8:0]  page;
    logic [11:0] po;
    logic        aligned;

    // Pins are foreign to this clock, so they pass two flops first
    iod_sync2 #(
        .W (2)
    ) u_strap_sync (
        .clk_sys_in (clk_sys_in),
        .d_in       (ext_bus_strap_in),
        .q_out      (strap_sync)
    );

    // Capture at the first edge after release; the sync pipe still shows reset-time pins
    always_ff @(posedge clk_sys_in or posedge reset_in) begin
        if (reset_in) begin
            captured_ff <= 1'b0;
            space_ff    <= IOD_SPACE_RST;
            base_ff     <= IOD_BASE_00;
        end else if (!captured_ff) begin
            captured_ff <= 1'b1;
            space_ff    <= strap_sync;
            base_ff     <= iod_base_of(strap_sync);
        end
    end

    assign space_out       = space_ff;
    assign base_out        = base_ff;
    assign space_valid_out = captured_ff;

    // Window is 2 MB aligned, so the offset is just the low address bits
    assign hit     = req_in.valid && captured_ff &&
                     (req_in.addr[31:IOD_WIN_LSB] == base_ff[31:IOD_WIN_LSB]);
    assign off     = req_in.addr[20:0];
    assign page    = off[20:12];
    assign po      = off[11:0];
    assign aligned = (po[1:0] == 2'h0);

    // One enumerated target per access keeps selects mutually exclusive
    always_comb begin
        nxt_sel = '0;
        if (hit) begin
            nxt_sel.valid    = 1'b1;
            nxt_sel.wr       = req_in.wr;
            nxt_sel.page_off = po;
            nxt_sel.tgt      = T_UNDEF;
            if (!off[20]) begin
                nxt_sel.tgt = T_EXT8;
            end else begin
                unique case (page)
                    PG_INTR: begin
                        if (aligned && po <= PO_MISC_LAST) begin
                            nxt_sel.tgt = T_INTR_REG;
                        end
                    end
                    PG_PDMA: begin
                        nxt_sel.tgt = T_PDMA_REG;
                    end
                    PG_PAR: begin
                        if (po == PO_ZERO) begin
                            nxt_sel.tgt = T_PAR_RST;
                        end else if (po >= PO_PAR_LO && po <= PO_PAR_HI
                                     && po != PO_PAR_HOLE) begin
                            nxt_sel.tgt = T_PAR_REG;
                        end
                    end
                    PG_PDRST: begin
                        nxt_sel.tgt = T_PDMA_RST;
                    end
                    PG_AUD: begin
                        if (po == PO_WORD1) begin
                            nxt_sel.tgt = T_AUD_RST;
                        end else if (aligned && (po <= PO_AUD_PIO || po == PO_AUD_DIAG)) begin
                            nxt_sel.tgt = T_AUD_REG;
                        end else if (po[11:3] == PO_AUD_SER0[11:3]
                                     && po[2:0] <= UART_AUD_TOP) begin
                            nxt_sel.tgt  = T_AUD_SER0;
                            nxt_sel.ureg = iod_uart_reg(po[2:0], divisor_latch_access_in[1]);
                        end else if (po[11:3] == PO_AUD_SER1[11:3]
                                     && po[2:0] <= UART_AUD_TOP) begin
                            nxt_sel.tgt  = T_AUD_SER1;
                            nxt_sel.ureg = iod_uart_reg(po[2:0], divisor_latch_access_in[2]);
                        end
                    end
                    PG_SER: begin
                        if (po == PO_ZERO) begin
                            nxt_sel.tgt = T_SER_RST;
                        end else if (po[11:3] == PO_SER_SET[11:3]) begin
                            nxt_sel.tgt  = T_SER_REG;
                            nxt_sel.ureg = iod_uart_reg(po[2:0],
                                                        divisor_latch_access_in[0]);
                        end
                    end
                    PG_SCSI: begin
                        if (po == PO_ZERO) begin
                            nxt_sel.tgt = T_SCSI_RST;
                        end else if (aligned && po >= PO_SCSI_LO && po <= PO_SCSI_HI) begin
                            nxt_sel.tgt = T_SCSI_REG;
                        end
                    end
                    PG_LAN: begin
                        if (po == PO_ZERO) begin
                            nxt_sel.tgt = T_LAN_RST;
                        end else if (po == PO_WORD1) begin
                            nxt_sel.tgt = T_LAN_CPU;
                        end else if (po == PO_WORD2) begin
                            nxt_sel.tgt = T_LAN_ATTN;
                        end
                    end
                    PG_KBD: begin
                        if (po == PO_ZERO) begin
                            nxt_sel.tgt = T_KBD_RST_ID;
                        end else if (po == PO_WORD1) begin
                            nxt_sel.tgt = T_KBD_DATA;
                        end else if (po == PO_WORD2) begin
                            nxt_sel.tgt = T_KBD_CTRL;
                        end
                    end
                    PG_RTC: begin
                        if (po == PO_ZERO) begin
                            nxt_sel.tgt = T_RTC;
                        end
                    end
                    PG_FLP: begin
                        if (po == PO_ZERO) begin
                            nxt_sel.tgt = T_FLP_RST;
                        end else if (po == PO_WORD1 || po == PO_WORD2 || po == PO_FLP_CTL
                                     || po == PO_FLP_OPS
                                     || (aligned && po >= PO_FLP_FDATA
                                         && po <= PO_FLP_FSTAT)) begin
                            nxt_sel.tgt = T_FLP_REG;
                        end
                    end
                    PG_CLK: begin
                        if (aligned && po <= PO_CLK_LAST) begin
                            nxt_sel.tgt = T_CLK_CFG;
                        end
                    end
                    PG_MISC: begin
                        if (aligned && po <= PO_MISC_LAST) begin
                            nxt_sel.tgt = T_MISC_REG;
                        end
                    end
                    default: begin
                        nxt_sel.tgt = T_UNDEF;
                    end
                endcase
            end
        end
    end

    // Registered select keeps downstream blocks free of decode glitches, at one cycle of latency
    always_ff @(posedge clk_sys_in or posedge reset_in) begin
        if (reset_in) begin
            sel_ff <= '0;
        end else begin
            sel_ff <= nxt_sel;
        end
    end

    assign sel_out = sel_ff;

    default clocking cb @(posedge clk_sys_in);
    endclocking
    default disable iff (reset_in);

    sequence s_req_at(logic [8:0] pg, logic [11:0] o);
        hit && page == pg && po == o;
    endsequence

    property p_strap_hold;
        captured_ff |=> $stable(space_ff) && captured_ff;
    endproperty
    a_strap_hold: assert property (p_strap_hold) else $error("Strap moved");

    property p_strap_take;
        !captured_ff |=> space_ff == $past(strap_sync);
    endproperty
    a_strap_take: assert property (p_strap_take) else $error("Strap not captured");

    property p_base_map;
        captured_ff |-> base_ff == iod_base_of(space_ff);
    endproperty
    a_base_map: assert property (p_base_map) else $error("Base does not match strap");

    property p_window_hit;
        hit |=> sel_out.valid && sel_out.tgt != T_NONE && sel_out.page_off == $past(po);
    endproperty
    a_window_hit: assert property (p_window_hit) else $error("Window access lost");

    property p_outside;
        !hit |=> !sel_out.valid && sel_out.tgt == T_NONE;
    endproperty
    a_outside: assert property (p_outside) else $error("Select outside the window");

    property p_pdma_rst;
        hit && page == PG_PDRST |=> sel_out.tgt == T_PDMA_RST;
    endproperty
    a_pdma_rst: assert property (p_pdma_rst) else $error("Parallel DMA reset missed");

    property p_lan_attn;
        s_req_at(PG_LAN, PO_WORD2) |=> sel_out.tgt == T_LAN_ATTN;
    endproperty
    a_lan_attn: assert property (p_lan_attn) else $error("Channel attention missed");

    property p_kbd_id;
        s_req_at(PG_KBD, PO_ZERO) |=> sel_out.tgt == T_KBD_RST_ID;
    endproperty
    a_kbd_id: assert property (p_kbd_id) else $error("Keyboard reset/ID missed");

    property p_divisor_latch_access;
        s_req_at(PG_SER, PO_SER_SET) ##0 divisor_latch_access_in[0]
            |=> sel_out.ureg == UR_DIV_LO;
    endproperty
    a_divisor_latch_access: assert property (p_divisor_latch_access) else $error("Divisor latch overlay missed");

    property p_scsi_rsvd;
        hit && page == PG_SCSI && po >= PO_WORD1 && po < PO_SCSI_LO
            |=> sel_out.tgt == T_UNDEF;
    endproperty
    a_scsi_rsvd: assert property (p_scsi_rsvd) else $error("SCSI gap selected");

    property p_par_hole;
        s_req_at(PG_PAR, PO_PAR_HOLE) |=> sel_out.tgt == T_UNDEF;
    endproperty
    a_par_hole: assert property (p_par_hole) else $error("Parallel hole selected");

    sequence s_req_rng(logic [8:0] pg, logic [11:0] lo, logic [11:0] hi);
        hit && page == pg && po >= lo && po <= hi;
    endsequence

    property p_par_rst;
        s_req_at(PG_PAR, PO_ZERO) |=> sel_out.tgt == T_PAR_RST;
    endproperty
    a_par_rst: assert property (p_par_rst) else $error("Parallel reset missed");

    property p_aud_rst;
        s_req_at(PG_AUD, PO_WORD1) |=> sel_out.tgt == T_AUD_RST;
    endproperty
    a_aud_rst: assert property (p_aud_rst) else $error("Audio reset missed");

    property p_ser_rst;
        s_req_at(PG_SER, PO_ZERO) |=> sel_out.tgt == T_SER_RST;
    endproperty
    a_ser_rst: assert property (p_ser_rst) else $error("Serial reset missed");

    property p_lan_rst;
        s_req_at(PG_LAN, PO_ZERO) |=> sel_out.tgt == T_LAN_RST;
    endproperty
    a_lan_rst: assert property (p_lan_rst) else $error("LAN reset missed");

    property p_lan_cpu;
        s_req_at(PG_LAN, PO_WORD1) |=> sel_out.tgt == T_LAN_CPU;
    endproperty
    a_lan_cpu: assert property (p_lan_cpu) else $error("LAN CPU port missed");

    property p_kbd_data;
        s_req_at(PG_KBD, PO_WORD1) |=> sel_out.tgt == T_KBD_DATA;
    endproperty
    a_kbd_data: assert property (p_kbd_data) else $error("Keyboard data missed");

    property p_ser_set;
        hit && page == PG_SER && po[11:3] == PO_SER_SET[11:3]
            |=> sel_out.tgt == T_SER_REG && sel_out.ureg != UR_NONE;
    endproperty
    a_ser_set: assert property (p_ser_set) else $error("Serial set missed");

    property p_aud_ser;
        hit && page == PG_AUD && po[11:3] == PO_AUD_SER1[11:3] && po[2:0] <= UART_AUD_TOP
            |=> sel_out.tgt == T_AUD_SER1 && sel_out.ureg != UR_NONE;
    endproperty
    a_aud_ser: assert property (p_aud_ser) else $error("Audio serial missed");

    property p_aud_regs;
        s_req_rng(PG_AUD, PO_WORD2, PO_AUD_PIO) ##0 aligned |=> sel_out.tgt == T_AUD_REG;
    endproperty
    a_aud_regs: assert property (p_aud_regs) else $error("Audio register missed");

    property p_par_regs;
        s_req_rng(PG_PAR, PO_PAR_LO, PO_PAR_HI) ##0 po != PO_PAR_HOLE
            |=> sel_out.tgt == T_PAR_REG;
    endproperty
    a_par_regs: assert property (p_par_regs) else $error("Parallel register missed");

    property p_scsi_core;
        s_req_rng(PG_SCSI, PO_SCSI_LO, PO_SCSI_HI) ##0 aligned |=> sel_out.tgt == T_SCSI_REG;
    endproperty
    a_scsi_core: assert property (p_scsi_core) else $error("SCSI core missed");

    property p_flp_fifo;
        s_req_rng(PG_FLP, PO_FLP_FDATA, PO_FLP_FSTAT) ##0 aligned
            |=> sel_out.tgt == T_FLP_REG;
    endproperty
    a_flp_fifo: assert property (p_flp_fifo) else $error("Floppy FIFO missed");

    property p_clk_cfg;
        s_req_rng(PG_CLK, PO_ZERO, PO_CLK_LAST) ##0 aligned |=> sel_out.tgt == T_CLK_CFG;
    endproperty
    a_clk_cfg: assert property (p_clk_cfg) else $error("Clock word missed");

    property p_misc_regs;
        s_req_rng(PG_MISC, PO_ZERO, PO_MISC_LAST) ##0 aligned |=> sel_out.tgt == T_MISC_REG;
    endproperty
    a_misc_regs: assert property (p_misc_regs) else $error("Misc word missed");

    property p_unassigned;
        hit && page > PG_MISC |=> sel_out.tgt == T_UNDEF;
    endproperty
    a_unassigned: assert property (p_unassigned) else $error("Unassigned hit");

    property p_ureg_serial;
        sel_out.ureg != UR_NONE |-> sel_out.tgt inside {T_SER_REG, T_AUD_SER0, T_AUD_SER1};
    endproperty
    a_ureg_serial: assert property (p_ureg_serial) else $error("Stray ureg");

endmodule
`default_nettype wire

// ==== rtl/iod_pkg.sv ====
package iod_pkg;

    // Window placement
    localparam logic [31:0] IOD_BASE_00 = 32'hF000_0000;
    localparam logic [31:0] IOD_BASE_01 = 32'hF040_0000;
    localparam logic [31:0] IOD_BASE_10 = 32'hFF80_0000;
    localparam logic [31:0] IOD_BASE_11 = 32'hFFC0_0000;
    localparam int          IOD_WIN_LSB = 21;
    localparam logic [1:0]  IOD_SPACE_RST = 2'h0;

    // Device pages: offset bits [20:12]
    localparam logic [8:0] PG_INTR  = 9'h100;
    localparam logic [8:0] PG_PDMA  = 9'h101;
    localparam logic [8:0] PG_PAR   = 9'h102;
    localparam logic [8:0] PG_PDRST = 9'h103;
    localparam logic [8:0] PG_AUD   = 9'h104;
    localparam logic [8:0] PG_SER   = 9'h105;
    localparam logic [8:0] PG_SCSI  = 9'h106;
    localparam logic [8:0] PG_LAN   = 9'h107;
    localparam logic [8:0] PG_KBD   = 9'h108;
    localparam logic [8:0] PG_RTC   = 9'h109;
    localparam logic [8:0] PG_FLP   = 9'h10A;
    localparam logic [8:0] PG_CLK   = 9'h10B;
    localparam logic [8:0] PG_MISC  = 9'h10C;

    // Offsets within a page
    localparam logic [11:0] PO_ZERO      = 12'h000;
    localparam logic [11:0] PO_WORD1     = 12'h004;
    localparam logic [11:0] PO_WORD2     = 12'h008;
    localparam logic [11:0] PO_PAR_LO    = 12'h800;
    localparam logic [11:0] PO_PAR_HOLE  = 12'h803;
    localparam logic [11:0] PO_PAR_HI    = 12'h807;
    localparam logic [11:0] PO_AUD_PIO   = 12'h028;
    localparam logic [11:0] PO_AUD_DIAG  = 12'h03C;
    localparam logic [11:0] PO_AUD_SER0  = 12'h040;
    localparam logic [11:0] PO_AUD_SER1  = 12'h060;
    localparam logic [11:0] PO_SER_SET   = 12'h800;
    localparam logic [11:0] PO_SCSI_LO   = 12'h100;
    localparam logic [11:0] PO_SCSI_HI   = 12'h13C;
    localparam logic [11:0] PO_FLP_FDATA = 12'h014;
    localparam logic [11:0] PO_FLP_FSTAT = 12'h01C;
    localparam logic [11:0] PO_FLP_CTL   = 12'h020;
    localparam logic [11:0] PO_FLP_OPS   = 12'h040;
    localparam logic [11:0] PO_CLK_LAST  = 12'h00C;
    localparam logic [11:0] PO_MISC_LAST = 12'h010;
    localparam logic [2:0]  UART_AUD_TOP = 3'h6;

    typedef enum logic [4:0] {
        T_NONE       = 5'h00,
        T_EXT8       = 5'h01,
        T_INTR_REG   = 5'h02,
        T_PDMA_REG   = 5'h03,
        T_PAR_RST    = 5'h04,
        T_PAR_REG    = 5'h05,
        T_PDMA_RST   = 5'h06,
        T_AUD_RST    = 5'h07,
        T_AUD_REG    = 5'h08,
        T_AUD_SER0   = 5'h09,
        T_AUD_SER1   = 5'h0A,
        T_SER_RST    = 5'h0B,
        T_SER_REG    = 5'h0C,
        T_SCSI_RST   = 5'h0D,
        T_SCSI_REG   = 5'h0E,
        T_LAN_RST    = 5'h0F,
        T_LAN_CPU    = 5'h10,
        T_LAN_ATTN   = 5'h11,
        T_KBD_RST_ID = 5'h12,
        T_KBD_DATA   = 5'h13,
        T_KBD_CTRL   = 5'h14,
        T_RTC        = 5'h15,
        T_FLP_RST    = 5'h16,
        T_FLP_REG    = 5'h17,
        T_CLK_CFG    = 5'h18,
        T_MISC_REG   = 5'h19,
        T_UNDEF      = 5'h1A
    } iod_tgt_t;

    typedef enum logic [3:0] {
        UR_NONE    = 4'h0,
        UR_DATA    = 4'h1,
        UR_DIV_LO  = 4'h2,
        UR_INT_EN  = 4'h3,
        UR_DIV_HI  = 4'h4,
        UR_IID_FCR = 4'h5,
        UR_LCR     = 4'h6,
        UR_MCR     = 4'h7,
        UR_LSR     = 4'h8,
        UR_MSR     = 4'h9,
        UR_SCRATCH = 4'hA
    } iod_ureg_t;

    typedef struct packed {
        logic        valid;
        logic        wr;
        logic [31:0] addr;
    } iod_req_t;

    typedef struct packed {
        logic        valid;
        logic        wr;
        iod_tgt_t    tgt;
        iod_ureg_t   ureg;
        logic [11:0] page_off;
    } iod_sel_t;

    function automatic logic [31:0] iod_base_of(input logic [1:0] space);
        logic [31:0] b;
        b = IOD_BASE_00;
        unique case (space)
            2'h0: b = IOD_BASE_00;
            2'h1: b = IOD_BASE_01;
            2'h2: b = IOD_BASE_10;
            2'h3: b = IOD_BASE_11;
        endcase
        return b;
    endfunction

    function automatic iod_ureg_t iod_uart_reg(input logic [2:0] idx, input logic dla);
        iod_ureg_t r;
        r = UR_NONE;
        unique case (idx)
            3'h0: r = dla ? UR_DIV_LO : UR_DATA;
            3'h1: r = dla ? UR_DIV_HI : UR_INT_EN;
            3'h2: r = UR_IID_FCR;
            3'h3: r = UR_LCR;
            3'h4: r = UR_MCR;
            3'h5: r = UR_LSR;
            3'h6: r = UR_MSR;
            3'h7: r = UR_SCRATCH;
        endcase
        return r;
    endfunction

endpackage

// ==== rtl/iod_sync2.sv ====
`timescale 1ns/1ps
`default_nettype none
// Plain two-stage synchroniser; no reset so the pins are tracked while reset is held
module iod_sync2 #(
    parameter int W = 2
) (
    input  wire logic         clk_sys_in,
    input  wire logic [W-1:0] d_in,
    output logic      [W-1:0] q_out
);
    logic [W-1:0] meta_ff;
    logic [W-1:0] q_ff;

    always_ff @(posedge clk_sys_in) begin
        meta_ff <= d_in;
        q_ff    <= meta_ff;
    end

    assign q_out = q_ff;
endmodule
`default_nettype wire

// ==== testbench/iod_bus_master.sv ====
`timescale 1ns/1ps
`default_nettype none
// Bus master model: one access per drive call, changed only at the falling edge
module iod_bus_master
    import iod_pkg::*;
(
    input  wire logic     clk_sys_in,
    output var  iod_req_t req_out
);
    initial req_out = '0;

    // A released bus shows the inverse of its last value, never a stale copy
    task automatic drive(input logic v, input logic w, input logic [31:0] a);
        @(negedge clk_sys_in);
        if (v) begin
            req_out <= {1'b1, w, a};
        end else begin
            req_out <= {1'b0, ~req_out.wr, ~req_out.addr};
        end
    endtask
endmodule
`default_nettype wire

// ==== testbench/tb_io_space_address_decoder.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb_io_space_address_decoder
    import iod_pkg::*;
;
    logic        clk_sys_in;
    logic        reset_in;
    logic [1:0]  strap;
    logic [2:0]  dla;
    iod_req_t    req;
    iod_sel_t    sel;
    logic [1:0]  space;
    logic [31:0] base;
    logic [31:0] cur_base;
    logic        space_vld;
    int          err_count;
    int          n_compared;
    logic [31:0] bases [4] = '{32'hF000_0000, 32'hF040_0000, 32'hFF80_0000, 32'hFFC0_0000};

    iod_bus_master BM (.clk_sys_in(clk_sys_in), .req_out(req));

    iod_decoder DUT (
        .clk_sys_in              (clk_sys_in),
        .reset_in                (reset_in),
        .ext_bus_strap_in        (strap),
        .req_in                  (req),
        .divisor_latch_access_in (dla),
        .sel_out                 (sel),
        .space_out               (space),
        .base_out                (base),
        .space_valid_out         (space_vld)
    );

    initial begin
        clk_sys_in = 1'b0;
        forever #2.5 clk_sys_in = ~clk_sys_in;
    end

    task automatic close_out();
        $display("COUNTS compared=%0d mismatches=%0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic cmp32(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic cmp_sel(input string what, input iod_sel_t exp, input iod_sel_t got);
        n_compared++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask

    function automatic iod_sel_t mk(logic [31:0] off, logic w, iod_tgt_t t, iod_ureg_t u);
        iod_sel_t e;
        e.valid = 1'b1;
        e.wr = w;
        e.tgt = t;
        e.ureg = u;
        e.page_off = off[11:0];
        return e;
    endfunction

    // One access, answer looked at in the cycle after the taking edge
    task automatic chk_dec(input logic [31:0] off, input iod_tgt_t t, input iod_ureg_t u,
                           input logic [2:0] d);
        logic w;
        w = off[0] ^ off[2];
        dla = d;
        BM.drive(1'b1, w, cur_base + off);
        BM.drive(1'b0, 1'b0, 32'h0000_0000);
        cmp_sel($sformatf("sel at %h", off), mk(off, w, t, u), sel);
    endtask

    task automatic chk_none(input logic [31:0] addr);
        BM.drive(1'b1, 1'b1, addr);
        BM.drive(1'b0, 1'b0, 32'h0000_0000);
        cmp_sel($sformatf("refused sel at %h", addr), '0, sel);
    endtask

    task automatic test_strap(input logic [1:0] code);
        @(negedge clk_sys_in);
        strap = code;
        reset_in = 1'b1;
        dla = 3'h0;
        repeat (18) @(negedge clk_sys_in);
        BM.drive(1'b1, 1'b0, bases[code] + 32'h0010_7008);
        BM.drive(1'b0, 1'b0, 32'h0000_0000);
        cmp_sel("sel in reset", '0, sel);
        cmp32("base in reset", IOD_BASE_00, base);
        cmp32("valid in reset", 32'h0000_0000, {31'h0, space_vld});
        reset_in = 1'b0;
        @(negedge clk_sys_in);
        cmp32("space", {30'h0, code}, {30'h0, space});
        cmp32("base", bases[code], base);
        cmp32("space valid", 32'h0000_0001, {31'h0, space_vld});
        // Pins move after capture; the latched code must not follow them
        strap = ~code;
        repeat (4) @(negedge clk_sys_in);
        cmp32("space held", {30'h0, code}, {30'h0, space});
        cmp32("base held", bases[code], base);
        cur_base = bases[code];
        chk_dec(32'h0010_7008, T_LAN_ATTN, UR_NONE, 3'h0);
        chk_dec(32'h001F_FFFC, T_UNDEF, UR_NONE, 3'h0);
        chk_none(cur_base + 32'h0020_0000);
        chk_none(bases[code ^ 2'h1] + 32'h0010_7008);
        $display("test strap %0d done", code);
    endtask

    task automatic test_decode();
        chk_dec(32'h0000_0000, T_EXT8, UR_NONE, 3'h0);
        chk_dec(32'h0010_3000, T_PDMA_RST, UR_NONE, 3'h0);
        chk_dec(32'h0010_3FFF, T_PDMA_RST, UR_NONE, 3'h0);
        chk_dec(32'h0010_2000, T_PAR_RST, UR_NONE, 3'h0);
        chk_dec(32'h0010_4004, T_AUD_RST, UR_NONE, 3'h0);
        chk_dec(32'h0010_5000, T_SER_RST, UR_NONE, 3'h0);
        chk_dec(32'h0010_6000, T_SCSI_RST, UR_NONE, 3'h0);
        chk_dec(32'h0010_7000, T_LAN_RST, UR_NONE, 3'h0);
        chk_dec(32'h0010_A000, T_FLP_RST, UR_NONE, 3'h0);
        chk_dec(32'h0010_7004, T_LAN_CPU, UR_NONE, 3'h0);
        chk_dec(32'h0010_8000, T_KBD_RST_ID, UR_NONE, 3'h0);
        chk_dec(32'h0010_8004, T_KBD_DATA, UR_NONE, 3'h0);
        chk_dec(32'h0010_8008, T_KBD_CTRL, UR_NONE, 3'h0);
        chk_dec(32'h0010_5800, T_SER_REG, UR_DATA, 3'h6);
        chk_dec(32'h0010_5800, T_SER_REG, UR_DIV_LO, 3'h1);
        chk_dec(32'h0010_5801, T_SER_REG, UR_INT_EN, 3'h6);
        chk_dec(32'h0010_5801, T_SER_REG, UR_DIV_HI, 3'h1);
        chk_dec(32'h0010_5807, T_SER_REG, UR_SCRATCH, 3'h0);
        chk_dec(32'h0010_5808, T_UNDEF, UR_NONE, 3'h0);
        chk_dec(32'h0010_4040, T_AUD_SER0, UR_DIV_LO, 3'h2);
        chk_dec(32'h0010_4046, T_AUD_SER0, UR_MSR, 3'h2);
        chk_dec(32'h0010_4047, T_UNDEF, UR_NONE, 3'h0);
        chk_dec(32'h0010_4061, T_AUD_SER1, UR_DIV_HI, 3'h4);
        chk_dec(32'h0010_4061, T_AUD_SER1, UR_INT_EN, 3'h3);
        chk_dec(32'h0010_4008, T_AUD_REG, UR_NONE, 3'h0);
        chk_dec(32'h0010_401C, T_AUD_REG, UR_NONE, 3'h0);
        chk_dec(32'h0010_403C, T_AUD_REG, UR_NONE, 3'h0);
        chk_dec(32'h0010_2800, T_PAR_REG, UR_NONE, 3'h0);
        chk_dec(32'h0010_2807, T_PAR_REG, UR_NONE, 3'h0);
        chk_dec(32'h0010_2803, T_UNDEF, UR_NONE, 3'h0);
        chk_dec(32'h0010_6100, T_SCSI_REG, UR_NONE, 3'h0);
        chk_dec(32'h0010_613C, T_SCSI_REG, UR_NONE, 3'h0);
        chk_dec(32'h0010_6004, T_UNDEF, UR_NONE, 3'h0);
        chk_dec(32'h0010_A004, T_FLP_REG, UR_NONE, 3'h0);
        chk_dec(32'h0010_A01C, T_FLP_REG, UR_NONE, 3'h0);
        chk_dec(32'h0010_A040, T_FLP_REG, UR_NONE, 3'h0);
        chk_dec(32'h0010_B000, T_CLK_CFG, UR_NONE, 3'h0);
        chk_dec(32'h0010_B00C, T_CLK_CFG, UR_NONE, 3'h0);
        chk_dec(32'h0010_B010, T_UNDEF, UR_NONE, 3'h0);
        chk_dec(32'h0010_C000, T_MISC_REG, UR_NONE, 3'h0);
        chk_dec(32'h0010_C010, T_MISC_REG, UR_NONE, 3'h0);
        chk_dec(32'h0010_D000, T_UNDEF, UR_NONE, 3'h0);
        chk_dec(32'h0010_0010, T_INTR_REG, UR_NONE, 3'h0);
        chk_dec(32'h0010_1010, T_PDMA_REG, UR_NONE, 3'h0);
        chk_dec(32'h0010_9000, T_RTC, UR_NONE, 3'h0);
        chk_dec(32'h0010_4000, T_AUD_REG, UR_NONE, 3'h0);
        chk_dec(32'h0010_4028, T_AUD_REG, UR_NONE, 3'h0);
        chk_dec(32'h0010_5001, T_UNDEF, UR_NONE, 3'h0);
        chk_dec(32'h0010_5802, T_SER_REG, UR_IID_FCR, 3'h0);
        chk_dec(32'h0010_5803, T_SER_REG, UR_LCR, 3'h1);
        chk_dec(32'h0010_5804, T_SER_REG, UR_MCR, 3'h0);
        chk_dec(32'h0010_5805, T_SER_REG, UR_LSR, 3'h0);
        chk_dec(32'h0010_4040, T_AUD_SER0, UR_DATA, 3'h5);
        chk_dec(32'h0010_A008, T_FLP_REG, UR_NONE, 3'h0);
        chk_dec(32'h0010_A020, T_FLP_REG, UR_NONE, 3'h0);
        chk_dec(32'h0010_C00C, T_MISC_REG, UR_NONE, 3'h0);
        $display("test decode done");
    endtask

    // Back to back: each answer stands one cycle, then the select drops
    task automatic test_b2b();
        dla = 3'h0;
        BM.drive(1'b1, 1'b0, cur_base + 32'h0010_5807);
        BM.drive(1'b1, 1'b1, cur_base + 32'h0010_6000);
        cmp_sel("first of pair", mk(32'h0010_5807, 1'b0, T_SER_REG, UR_SCRATCH), sel);
        BM.drive(1'b0, 1'b0, 32'h0000_0000);
        cmp_sel("second of pair", mk(32'h0010_6000, 1'b1, T_SCSI_RST, UR_NONE), sel);
        @(negedge clk_sys_in);
        cmp_sel("after pair", '0, sel);
        $display("test back to back done");
    endtask

    initial begin
        err_count = 0;
        n_compared = 0;
        reset_in = 1'b1;
        strap = 2'h0;
        dla = 3'h0;
        // Ends on code 00, the primary strap, which the decode table then uses
        for (int c = 3; c >= 0; c--) begin
            test_strap(c[1:0]);
        end
        test_decode();
        test_b2b();
        close_out();
    end

    initial begin
        repeat (20000) @(posedge clk_sys_in);
        err_count++;
        close_out();
    end
endmodule
`default_nettype wire
